// ===== src/nv_user_rom_params.svh
// Purpose: Constants for the user nonvolatile byte store
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef NV_USER_ROM_PARAMS_SVH
`define NV_USER_ROM_PARAMS_SVH

`define NV_BANK_COUNT      8
`define NV_BYTES_PER_BANK  16
`define NV_WORD_COUNT      128
`define NV_ADDR_W          7
`define NV_BANK_W          3
`define NV_BYTE_W          4
`define NV_DATA_W          8
`define NV_BANK_MSB        6
`define NV_BANK_LSB        4
`define NV_BYTE_MSB        3
`define NV_BYTE_LSB        0
`define NV_JTAG_READ_IDLE  1'b0
`define NV_DATA_RESET      8'h00
`define NV_ERASED_BYTE     8'hff

`endif

// ===== src/nv_user_rom_pkg.sv
// Purpose: Types for the user nonvolatile byte store
// Assumes: Constants come from nv_user_rom_params.svh
// Notes:   Nothing here is imported; users write the package name
`include "nv_user_rom_params.svh"

package nv_user_rom_pkg;

  typedef logic [`NV_ADDR_W-1:0] rom_addr_t;
  typedef logic [`NV_BANK_W-1:0] bank_sel_t;
  typedef logic [`NV_BYTE_W-1:0] byte_sel_t;
  typedef logic [`NV_DATA_W-1:0] rom_byte_t;

  typedef enum logic [1:0] {
    PROG_IDLE  = 2'b00,
    PROG_ERASE = 2'b01,
    PROG_WRITE = 2'b10
  } prog_state_t;

endpackage

// ===== src/nv_user_rom_array.sv
// Purpose: Storage array of 128 bytes with a registered read port
// Assumes: One write port, used only by the programming path
// Notes:   Read data come out of a register
`timescale 1ns/10ps
`include "nv_user_rom_params.svh"

module nv_user_rom_array (
  input  wire logic                       clk_sys_in,
  input  wire logic                       wr_en_in,
  input  wire nv_user_rom_pkg::rom_addr_t wr_addr_in,
  input  wire nv_user_rom_pkg::rom_byte_t wr_data_in,
  input  wire nv_user_rom_pkg::rom_addr_t rd_addr_in,
  output nv_user_rom_pkg::rom_byte_t      rd_data_out
);

  nv_user_rom_pkg::rom_byte_t mem_reg [0:`NV_WORD_COUNT-1];
  nv_user_rom_pkg::rom_byte_t rd_data_reg;

  // ==========================================================
  // Write port
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // ==========================================================
  // Registered read port
  always_ff @(posedge clk_sys_in) begin
    rd_data_reg <= mem_reg[rd_addr_in];
  end

  assign rd_data_out = rd_data_reg;

endmodule

// ===== src/nv_user_rom_byte_reader.sv
// Purpose: User nonvolatile byte store read by fabric logic one byte per access
// Assumes: All inputs synchronous to clk_sys_in
// Notes:   Programming path is the JTAG side; fabric writes are ignored
//
// Contract
// - Storage is eight banks of 128 bits, sixteen bytes each.
// - Reads return one byte per access on a clocked synchronous port.
// - Upper three address bits select one of eight banks.
// - Lower four address bits select the byte within the bank.
// - Erase and write only via JTAG; fabric write attempts ignored.
// - Contents readable through both JTAG and fabric addressing.
`timescale 1ns/10ps
`include "nv_user_rom_params.svh"

module nv_user_rom_byte_reader (
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_n_in,
  // Fabric read port
  input  wire logic                       rd_en_in,
  input  wire nv_user_rom_pkg::rom_addr_t rd_addr_in,
  output nv_user_rom_pkg::rom_byte_t      rd_data_out,
  output logic                            rd_valid_out,
  // Fabric write attempt, always ignored
  input  wire logic                       fab_wr_en_in,
  input  wire nv_user_rom_pkg::rom_addr_t fab_wr_addr_in,
  input  wire nv_user_rom_pkg::rom_byte_t fab_wr_data_in,
  output logic                            fab_wr_reject_out,
  // JTAG programming side
  input  wire logic                       jtag_erase_in,
  input  wire logic                       jtag_wr_en_in,
  input  wire nv_user_rom_pkg::rom_addr_t jtag_addr_in,
  input  wire nv_user_rom_pkg::rom_byte_t jtag_wr_data_in,
  input  wire logic                       jtag_rd_en_in,
  output nv_user_rom_pkg::rom_byte_t      jtag_rd_data_out,
  output logic                            jtag_rd_valid_out,
  output logic                            jtag_busy_out
);

  // ==========================================================
  // Address decode
  function automatic nv_user_rom_pkg::rom_addr_t flat_index(
    input nv_user_rom_pkg::bank_sel_t bank,
    input nv_user_rom_pkg::byte_sel_t byte_sel
  );
    flat_index = {bank, byte_sel};
  endfunction

  function automatic nv_user_rom_pkg::bank_sel_t bank_of(input nv_user_rom_pkg::rom_addr_t a);
    bank_of = a[`NV_BANK_MSB:`NV_BANK_LSB];
  endfunction

  function automatic nv_user_rom_pkg::byte_sel_t byte_of(input nv_user_rom_pkg::rom_addr_t a);
    byte_of = a[`NV_BYTE_MSB:`NV_BYTE_LSB];
  endfunction

  nv_user_rom_pkg::prog_state_t prog_state_reg;
  nv_user_rom_pkg::prog_state_t prog_state_next;
  nv_user_rom_pkg::rom_addr_t   erase_ptr_reg;
  nv_user_rom_pkg::rom_addr_t   arr_rd_addr;
  nv_user_rom_pkg::rom_addr_t   arr_wr_addr;
  nv_user_rom_pkg::rom_byte_t   arr_wr_data;
  nv_user_rom_pkg::rom_byte_t   arr_rd_data;
  nv_user_rom_pkg::rom_byte_t   rd_data_reg;
  nv_user_rom_pkg::rom_byte_t   jtag_rd_data_reg;
  logic                         arr_wr_en;
  logic                         fab_pend_reg;
  logic                         jtag_pend_reg;
  logic                         rd_valid_reg;
  logic                         jtag_rd_valid_reg;
  logic                         fab_wr_reject_reg;
  logic                         jtag_busy_reg;
  logic                         jtag_rd_go;

  // ==========================================================
  // Programming state machine, JTAG side only
  always_comb begin
    prog_state_next = prog_state_reg;
    case (prog_state_reg)
      nv_user_rom_pkg::PROG_IDLE: begin
        if (jtag_erase_in) begin
          prog_state_next = nv_user_rom_pkg::PROG_ERASE;
        end else if (jtag_wr_en_in) begin
          prog_state_next = nv_user_rom_pkg::PROG_WRITE;
        end
      end
      nv_user_rom_pkg::PROG_ERASE: begin
        if (erase_ptr_reg == 7'(`NV_WORD_COUNT - 1)) begin
          prog_state_next = nv_user_rom_pkg::PROG_IDLE;
        end
      end
      nv_user_rom_pkg::PROG_WRITE: begin
        prog_state_next = nv_user_rom_pkg::PROG_IDLE;
      end
      default: begin
        prog_state_next = nv_user_rom_pkg::PROG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      prog_state_reg <= nv_user_rom_pkg::PROG_IDLE;
    end else begin
      prog_state_reg <= prog_state_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      erase_ptr_reg <= '0;
    end else if (prog_state_reg == nv_user_rom_pkg::PROG_ERASE) begin
      erase_ptr_reg <= erase_ptr_reg + 7'h01;
    end else begin
      erase_ptr_reg <= '0;
    end
  end

  // Write address and data latched when a JTAG write is accepted
  nv_user_rom_pkg::rom_addr_t jtag_wr_addr_reg;
  nv_user_rom_pkg::rom_byte_t jtag_wr_data_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      jtag_wr_addr_reg <= '0;
      jtag_wr_data_reg <= `NV_DATA_RESET;
    end else if (prog_state_reg == nv_user_rom_pkg::PROG_IDLE && jtag_wr_en_in) begin
      jtag_wr_addr_reg <= jtag_addr_in;
      jtag_wr_data_reg <= jtag_wr_data_in;
    end
  end

  // Only the JTAG path reaches the array write port; fabric inputs do not
  always_comb begin
    arr_wr_en   = 1'b0;
    arr_wr_addr = jtag_wr_addr_reg;
    arr_wr_data = jtag_wr_data_reg;
    case (prog_state_reg)
      nv_user_rom_pkg::PROG_ERASE: begin
        arr_wr_en   = 1'b1;
        arr_wr_addr = erase_ptr_reg;
        arr_wr_data = `NV_ERASED_BYTE;
      end
      nv_user_rom_pkg::PROG_WRITE: begin
        arr_wr_en = 1'b1;
      end
      default: begin
        arr_wr_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      jtag_busy_reg <= 1'b0;
    end else begin
      jtag_busy_reg <= (prog_state_next != nv_user_rom_pkg::PROG_IDLE);
    end
  end

  // Fabric write attempts are flagged and dropped
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      fab_wr_reject_reg <= 1'b0;
    end else begin
      fab_wr_reject_reg <= fab_wr_en_in;
    end
  end

  // ==========================================================
  // Read arbitration: fabric read owns the port; JTAG readback uses idle cycles
  assign jtag_rd_go = jtag_rd_en_in && !rd_en_in;

  assign arr_rd_addr = rd_en_in ? flat_index(bank_of(rd_addr_in), byte_of(rd_addr_in))
                                : jtag_addr_in;

  nv_user_rom_array u_array (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (arr_wr_en),
    .wr_addr_in  (arr_wr_addr),
    .wr_data_in  (arr_wr_data),
    .rd_addr_in  (arr_rd_addr),
    .rd_data_out (arr_rd_data)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      fab_pend_reg  <= 1'b0;
      jtag_pend_reg <= `NV_JTAG_READ_IDLE;
    end else begin
      fab_pend_reg  <= rd_en_in;
      jtag_pend_reg <= jtag_rd_go;
    end
  end

  // Fabric byte output, held until the next fabric read returns
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rd_data_reg  <= `NV_DATA_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= fab_pend_reg;
      if (fab_pend_reg) begin
        rd_data_reg <= arr_rd_data;
      end
    end
  end

  // JTAG readback output
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      jtag_rd_data_reg  <= `NV_DATA_RESET;
      jtag_rd_valid_reg <= 1'b0;
    end else begin
      jtag_rd_valid_reg <= jtag_pend_reg;
      if (jtag_pend_reg) begin
        jtag_rd_data_reg <= arr_rd_data;
      end
    end
  end

  assign rd_data_out       = rd_data_reg;
  assign rd_valid_out      = rd_valid_reg;
  assign jtag_rd_data_out  = jtag_rd_data_reg;
  assign jtag_rd_valid_out = jtag_rd_valid_reg;
  assign fab_wr_reject_out = fab_wr_reject_reg;
  assign jtag_busy_out     = jtag_busy_reg;

endmodule

// ===== dv/nv_user_rom_byte_reader_asserts.sv
// Purpose: Port checks for the byte reader
// Assumes: Bound to the reader top
// Notes:   Read answer two edges after take
`timescale 1ns/10ps
module nv_user_rom_byte_reader_asserts (
  input wire logic                       clk_sys_in,
  input wire logic                       reset_n_in,
  input wire logic                       rd_en_in,
  input wire nv_user_rom_pkg::rom_byte_t rd_data_out,
  input wire logic                       rd_valid_out,
  input wire logic                       fab_wr_en_in,
  input wire logic                       fab_wr_reject_out,
  input wire logic                       jtag_erase_in,
  input wire logic                       jtag_wr_en_in,
  input wire logic                       jtag_rd_en_in,
  input wire logic                       jtag_rd_valid_out,
  input wire logic                       jtag_busy_out
);
  // ====
  // Properties
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_rd_lat; rd_en_in |-> ##2 rd_valid_out; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read");
  property p_rd_src; rd_valid_out |-> $past(rd_en_in, 2); endproperty
  a_rd_src: assert property (p_rd_src) else $error("stray read");
  property p_hold; !rd_valid_out |-> $stable(rd_data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_rej; fab_wr_en_in |=> fab_wr_reject_out; endproperty
  a_rej: assert property (p_rej) else $error("no reject");
  property p_jrd; jtag_rd_en_in && !rd_en_in |-> ##2 jtag_rd_valid_out; endproperty
  a_jrd: assert property (p_jrd) else $error("late readback");
  property p_jdrop; jtag_rd_en_in && rd_en_in |-> ##2 !jtag_rd_valid_out; endproperty
  a_jdrop: assert property (p_jdrop) else $error("readback won");
  property p_wr; jtag_wr_en_in && !jtag_erase_in && !jtag_busy_out
    |=> jtag_busy_out ##1 !jtag_busy_out; endproperty
  a_wr: assert property (p_wr) else $error("write busy");
  property p_er; jtag_erase_in && !jtag_busy_out |=> jtag_busy_out [*8]; endproperty
  a_er: assert property (p_er) else $error("erase busy");
endmodule

bind nv_user_rom_byte_reader nv_user_rom_byte_reader_asserts chk (.clk_sys_in, .reset_n_in,
  .rd_en_in, .rd_data_out, .rd_valid_out, .fab_wr_en_in, .fab_wr_reject_out, .jtag_erase_in,
  .jtag_wr_en_in, .jtag_rd_en_in, .jtag_rd_valid_out, .jtag_busy_out);

// ===== dv/fabric_reader_model.sv
// Purpose: Fabric user logic issuing byte reads
// Assumes: Requests change off the rising edge
// Notes:   Idle address shows the inverse of the last one
`timescale 1ns/10ps
module fabric_reader_model (
  input  wire logic                       clk_sys_in,
  input  wire logic                       req_in,
  input  wire nv_user_rom_pkg::rom_addr_t req_addr_in,
  output logic                            rd_en_out,
  output nv_user_rom_pkg::rom_addr_t      rd_addr_out
);
  // ====
  // Request drive
  nv_user_rom_pkg::rom_addr_t last_reg;
  always_ff @(posedge clk_sys_in) begin
    if (req_in) begin
      last_reg <= req_addr_in;
    end
  end
  assign rd_en_out = req_in;
  assign rd_addr_out = req_in ? req_addr_in : ~last_reg;
endmodule

// ===== dv/nv_user_rom_byte_reader_bench.sv
// Purpose: Self-checking bench for the byte reader
// Assumes: Inputs driven at the falling edge
// Notes:   Expected bytes kept in a bench array
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t %h %h", $time, g, e); end end
module nv_user_rom_byte_reader_bench;
  logic clk_sys_in, reset_n_in, req, rd_en_in, rd_valid_out, fab_wr_en_in, fab_wr_reject_out;
  logic jtag_erase_in, jtag_wr_en_in, jtag_rd_en_in, jtag_rd_valid_out, jtag_busy_out;
  nv_user_rom_pkg::rom_addr_t req_addr, rd_addr_in, fab_wr_addr_in, jtag_addr_in;
  nv_user_rom_pkg::rom_byte_t rd_data_out, fab_wr_data_in, jtag_wr_data_in, jtag_rd_data_out;
  nv_user_rom_pkg::rom_byte_t mem [128];
  nv_user_rom_pkg::rom_byte_t q [$];
  nv_user_rom_pkg::rom_byte_t jq [$];
  nv_user_rom_pkg::rom_addr_t corners [5] = '{7'h00, 7'h0f, 7'h10, 7'h70, 7'h7f};
  logic [31:0] r;
  nv_user_rom_pkg::rom_byte_t fab_exp;
  nv_user_rom_pkg::rom_byte_t jtag_exp;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h64d6;

  fabric_reader_model fab (.clk_sys_in, .req_in(req), .req_addr_in(req_addr),
    .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in));
  nv_user_rom_byte_reader dut (.*);

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ====
  // Helpers
  function automatic nv_user_rom_pkg::rom_byte_t exp_at(input logic [2:0] bank,
                                                       input logic [3:0] idx);
    return mem[bank * 16 + idx];
  endfunction

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic jprog(input nv_user_rom_pkg::rom_addr_t a, input nv_user_rom_pkg::rom_byte_t d,
                       input logic er);
    jtag_addr_in = a;
    jtag_wr_data_in = d;
    jtag_wr_en_in = !er;
    jtag_erase_in = er;
    @(negedge clk_sys_in);
    jtag_wr_en_in = 1'b0;
    jtag_erase_in = 1'b0;
    for (int i = 0; i < 200 && jtag_busy_out; i++) @(negedge clk_sys_in);
    `CHK(jtag_busy_out, 1'b0)
    @(negedge clk_sys_in);
    if (er) foreach (mem[i]) mem[i] = 8'hff;
    else mem[a] = d;
  endtask

  task automatic step(input logic re, je, fw, input nv_user_rom_pkg::rom_addr_t ra, ja);
    req = re;
    req_addr = ra;
    jtag_rd_en_in = je;
    jtag_addr_in = ja;
    fab_wr_en_in = fw;
    fab_wr_addr_in = ja;
    fab_wr_data_in = ~mem[ja];
    if (re) q.push_back(exp_at(ra[6:4], ra[3:0]));
    else if (je) jq.push_back(exp_at(ja[6:4], ja[3:0]));
    @(negedge clk_sys_in);
  endtask

  task automatic sweep(input logic j);
    for (int i = 0; i < 128; i++) step(!j, j, i[0], 7'(i), 7'(i));
    repeat (3) step(1'b0, 1'b0, 1'b0, 7'h00, 7'h00);
  endtask

  always @(negedge clk_sys_in) begin
    if (reset_n_in === 1'b1 && rd_valid_out === 1'b1) begin
      `CHK(q.size() != 0, 1'b1)
      if (q.size() != 0) begin
        fab_exp = q.pop_front();
        `CHK(rd_data_out, fab_exp)
      end
    end
    if (reset_n_in === 1'b1 && jtag_rd_valid_out === 1'b1) begin
      `CHK(jq.size() != 0, 1'b1)
      if (jq.size() != 0) begin
        jtag_exp = jq.pop_front();
        `CHK(jtag_rd_data_out, jtag_exp)
      end
    end
  end

  // ====
  // Sequence
  initial begin
    {reset_n_in, req, req_addr, jtag_erase_in, jtag_wr_en_in, jtag_rd_en_in} = '0;
    {fab_wr_en_in, fab_wr_addr_in, fab_wr_data_in, jtag_addr_in, jtag_wr_data_in} = '0;
    repeat (4) @(negedge clk_sys_in);
    `CHK({rd_valid_out, rd_data_out, jtag_busy_out}, 10'h000)
    `CHK({jtag_rd_valid_out, jtag_rd_data_out, fab_wr_reject_out}, 10'h000)
    reset_n_in = 1'b1;
    @(negedge clk_sys_in);
    jprog(7'h00, 8'h00, 1'b1);
    sweep(1'b0);
    foreach (corners[i]) jprog(corners[i], {1'b0, corners[i]} ^ 8'ha5, 1'b0);
    repeat (8) begin
      r = $random(seed);
      jprog(r[6:0], r[14:7], 1'b0);
    end
    sweep(1'b0);
    sweep(1'b1);
    repeat (400) begin
      r = $random(seed);
      step(r[0], r[1], r[2], r[9:3], r[16:10]);
    end
    sweep(1'b0);
    `CHK(q.size() + jq.size(), 0)
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_errors++;
    wrap_up;
  end
endmodule
